// ---- rtl/status_map.svh ----
// Offsets, field positions, masks and reset values of the status register bank
`ifndef STATUS_MAP_SVH
`define STATUS_MAP_SVH

// ***********************************************
// Register offsets on the host register port
// ***********************************************
`define OFS_CONTROLLER_FAULT_FLAGS       8'hE2
`define OFS_ALGORITHM_STATUS             8'hE4
`define OFS_MEASURED_MOTOR_PARAMETERS    8'hE6
`define OFS_PARAMETER_MEASUREMENT_STATUS 8'hE8

// ***********************************************
// Reset value of every status word
// ***********************************************
`define STATUS_RESET 32'h0000_0000

// ***********************************************
// Controller fault flag positions
// ***********************************************
`define BIT_FAULT_SUMMARY        31
`define BIT_OVERTEMP_MCE         30
`define BIT_POS_FREQ_ERR         29
`define BIT_POS_TIMING1_ERR      28
`define BIT_POS_TIMING2_ERR      27
`define BIT_BUS_CURRENT_LIMIT    26
`define BIT_RL_MEASURE_ERR       25
`define BIT_BACKEMF_MEASURE_ERR  24
`define BIT_ABNORMAL_SPEED_LOCK  23
`define BIT_ABNORMAL_BEMF_LOCK   22
`define BIT_MOTOR_ABSENT         21
`define BIT_ROTOR_LOCK_ANY       20
`define BIT_LOCK_CURRENT_LIMIT   19
`define BIT_HARDWARE_LOCK_CURRENT_LIMIT        18
`define BIT_SUPPLY_LOW           17
`define BIT_SUPPLY_HIGH          16
`define BIT_SPEED_LOOP_SAT       15
`define BIT_CURRENT_LOOP_SAT     14
`define BIT_WATCHDOG_ERR         3
`define BIT_SELFTEST_ENABLED     2
`define BIT_SELFTEST_STATE       1
`define BIT_APP_RESET            0

// Sticky events, live levels, and the lock kinds behind the lock summary
`define FAULT_STICKY_MASK 32'h7BEF_0009
`define FAULT_LEVEL_MASK  32'h0400_C006
`define FAULT_LOCK_MASK   32'h00EC_0000

// ***********************************************
// Algorithm status and motor parameter fields
// ***********************************************
`define VOLT_MSB       31
`define VOLT_LSB       16
`define SPEED_CMD_MSB  15
`define SPEED_CMD_LSB  4
`define BIT_INIT_DONE  3
`define BIT_HOST_CTRL  2
`define RES_MSB        31
`define RES_LSB        24
`define KE_MSB         23
`define KE_LSB         16
`define IND_MSB        15
`define IND_LSB        8

`endif

// ---- rtl/status_pkg.sv ----
// Types carried between the status register bank and its neighbours
package status_pkg;

  typedef struct packed {
    logic overtemp_mce;
    logic position_detect_freq_err;
    logic position_detect_timing1_err;
    logic position_detect_timing2_err;
    logic bus_current_limit_active;
    logic rl_measure_err;
    logic backemf_measure_err;
    logic abnormal_speed_lock;
    logic abnormal_backemf_lock;
    logic motor_absent;
    logic lock_current_limit;
    logic hardware_lock_current_limit;
    logic motor_supply_low;
    logic motor_supply_high;
    logic speed_loop_saturated;
    logic current_loop_saturated;
    logic watchdog_err;
    logic selftest_enabled;
    logic selftest_state;
    logic app_reset;
  } fault_src_t;

  typedef struct packed {
    logic [15:0] applied_voltage_level;
    logic [11:0] speed_command;
    logic        init_complete;
    logic        host_control_allowed;
  } algo_src_t;

  typedef struct packed {
    logic [7:0] resistance;
    logic [7:0] measured_backemf_constant;
    logic [7:0] inductance;
  } motor_params_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } host_rsp_t;

endpackage

// ---- rtl/status_regs.sv ----
// Read-only status register bank of the sensorless motor controller
//
// Function
// - Fault summary bit is OR of all flags
// - Three separate position detection fault flags
// - Bus current limit active has own flag
// - R/L and back-EMF measure errors, adjacent bits
// - Speed lock, back-EMF lock, no-motor flags
// - Lock summary set when any lock fires
// - Lock and hardware lock current-limit flags separate
// - Supply undervoltage and overvoltage flags separate
// - Speed and current loop saturation flags
// - Applied voltage magnitude in upper half
// - Twelve-bit decoded speed command field
// - Init-complete flag zero until copy done
// - Host-control flag zero until defaults copied
// - Resistance in top parameter byte
// - Back-EMF constant in second parameter byte
// - Inductance in third byte, lowest reserved
`include "status_map.svh"
`timescale 1ns/1ns
`default_nettype none

module status_regs (
  input  wire logic                       clock,
  input  wire logic                       rst,
  input  wire status_pkg::host_req_t      host_req,
  output var  status_pkg::host_rsp_t      host_rsp,
  input  wire status_pkg::fault_src_t     fault_src,
  input  wire logic                       fault_clear,
  input  wire status_pkg::algo_src_t      algo_src,
  input  wire logic                       params_load,
  input  wire status_pkg::motor_params_t  params_in,
  input  wire logic                       measure_status_load,
  input  wire logic [31:0]                measure_status_in,
  output logic                            controller_fault
);
  import status_pkg::*;

  // ***********************************************
  // Fault sources placed at their flag positions
  // ***********************************************
  logic [31:0] fault_raw;
  wire  [30:0] fault_flags_next;
  logic [30:0] fault_flags_reg;
  logic        controller_fault_reg;
  logic        lock_any;
  logic [31:0] controller_fault_flags;

  // Bits 31 and 20 are summaries and have no source of their own
  always_comb begin
    fault_raw                            = '0;
    fault_raw[`BIT_OVERTEMP_MCE]         = fault_src.overtemp_mce;
    fault_raw[`BIT_POS_FREQ_ERR]         = fault_src.position_detect_freq_err;
    fault_raw[`BIT_POS_TIMING1_ERR]      = fault_src.position_detect_timing1_err;
    fault_raw[`BIT_POS_TIMING2_ERR]      = fault_src.position_detect_timing2_err;
    fault_raw[`BIT_BUS_CURRENT_LIMIT]    = fault_src.bus_current_limit_active;
    fault_raw[`BIT_RL_MEASURE_ERR]       = fault_src.rl_measure_err;
    fault_raw[`BIT_BACKEMF_MEASURE_ERR]  = fault_src.backemf_measure_err;
    fault_raw[`BIT_ABNORMAL_SPEED_LOCK]  = fault_src.abnormal_speed_lock;
    fault_raw[`BIT_ABNORMAL_BEMF_LOCK]   = fault_src.abnormal_backemf_lock;
    fault_raw[`BIT_MOTOR_ABSENT]         = fault_src.motor_absent;
    fault_raw[`BIT_LOCK_CURRENT_LIMIT]   = fault_src.lock_current_limit;
    fault_raw[`BIT_HARDWARE_LOCK_CURRENT_LIMIT]        = fault_src.hardware_lock_current_limit;
    fault_raw[`BIT_SUPPLY_LOW]           = fault_src.motor_supply_low;
    fault_raw[`BIT_SUPPLY_HIGH]          = fault_src.motor_supply_high;
    fault_raw[`BIT_SPEED_LOOP_SAT]       = fault_src.speed_loop_saturated;
    fault_raw[`BIT_CURRENT_LOOP_SAT]     = fault_src.current_loop_saturated;
    fault_raw[`BIT_WATCHDOG_ERR]         = fault_src.watchdog_err;
    fault_raw[`BIT_SELFTEST_ENABLED]     = fault_src.selftest_enabled;
    fault_raw[`BIT_SELFTEST_STATE]       = fault_src.selftest_state;
    fault_raw[`BIT_APP_RESET]            = fault_src.app_reset;
  end

  // ***********************************************
  // Per-bit flag storage
  // ***********************************************
  // Sticky flags hold an event until cleared; a new event in the
  // clearing cycle wins so it is never lost. Level flags follow
  // their source one cycle late. Reserved bits are tied to zero.
  localparam logic [31:0] STICKY_MASK = `FAULT_STICKY_MASK;
  localparam logic [31:0] LEVEL_MASK  = `FAULT_LEVEL_MASK;
  localparam logic [31:0] LOCK_MASK   = `FAULT_LOCK_MASK;

  genvar i;
  generate
    for (i = 0; i < 31; i = i + 1) begin : g_flag
      if (STICKY_MASK[i]) begin : g_sticky
        assign fault_flags_next[i] = fault_raw[i] | (fault_flags_reg[i] & ~fault_clear);
      end else if (LEVEL_MASK[i]) begin : g_level
        assign fault_flags_next[i] = fault_raw[i];
      end else begin : g_zero
        assign fault_flags_next[i] = 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (rst) begin
      fault_flags_reg <= '0;
    end else begin
      fault_flags_reg <= fault_flags_next;
    end
  end

  // Summary is taken from the next flag values so it moves in step
  // with the flags it summarises
  always_ff @(posedge clock) begin
    if (rst) begin
      controller_fault_reg <= 1'b0;
    end else begin
      controller_fault_reg <= |fault_flags_next;
    end
  end

  // ***********************************************
  // Summary flags
  // ***********************************************
  // Lock summary covers the five lock kinds only
  assign lock_any = |({1'b0, fault_flags_reg} & LOCK_MASK);

  always_comb begin
    controller_fault_flags                      = {1'b0, fault_flags_reg};
    controller_fault_flags[`BIT_ROTOR_LOCK_ANY] = lock_any;
    controller_fault_flags[`BIT_FAULT_SUMMARY]  = controller_fault_reg;
  end

  assign controller_fault = controller_fault_reg;

  // ***********************************************
  // Algorithm status word
  // ***********************************************
  logic [15:0] voltage_reg;
  logic [11:0] speed_cmd_reg;
  logic        init_complete_reg;
  logic        host_control_reg;
  logic [31:0] algorithm_status;

  // Live magnitude and speed command, one cycle behind the algorithm
  always_ff @(posedge clock) begin
    if (rst) begin
      voltage_reg <= '0;
    end else begin
      voltage_reg <= algo_src.applied_voltage_level;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      speed_cmd_reg <= '0;
    end else begin
      speed_cmd_reg <= algo_src.speed_command;
    end
  end

  // Both readiness flags stay low from reset until the copy engines report
  // Init flag: low while configuration is still being copied
  always_ff @(posedge clock) begin
    if (rst) begin
      init_complete_reg <= 1'b0;
    end else begin
      init_complete_reg <= algo_src.init_complete;
    end
  end

  // Host flag: low while defaults are still being loaded
  always_ff @(posedge clock) begin
    if (rst) begin
      host_control_reg <= 1'b0;
    end else begin
      host_control_reg <= algo_src.host_control_allowed;
    end
  end

  always_comb begin
    algorithm_status                                = `STATUS_RESET;
    algorithm_status[`VOLT_MSB:`VOLT_LSB]           = voltage_reg;
    algorithm_status[`SPEED_CMD_MSB:`SPEED_CMD_LSB] = speed_cmd_reg;
    algorithm_status[`BIT_INIT_DONE]                = init_complete_reg;
    algorithm_status[`BIT_HOST_CTRL]                = host_control_reg;
  end

  // ***********************************************
  // Measured motor parameters
  // ***********************************************
  // Held between measurements; updated only on a load strobe
  logic [7:0]  resistance_reg;
  logic [7:0]  backemf_const_reg;
  logic [7:0]  inductance_reg;
  logic [31:0] measured_motor_parameters;

  always_ff @(posedge clock) begin
    if (rst) begin
      resistance_reg <= '0;
    end else if (params_load) begin
      resistance_reg <= params_in.resistance;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      backemf_const_reg <= '0;
    end else if (params_load) begin
      backemf_const_reg <= params_in.measured_backemf_constant;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      inductance_reg <= '0;
    end else if (params_load) begin
      inductance_reg <= params_in.inductance;
    end
  end

  always_comb begin
    measured_motor_parameters                   = `STATUS_RESET;
    measured_motor_parameters[`RES_MSB:`RES_LSB] = resistance_reg;
    measured_motor_parameters[`KE_MSB:`KE_LSB]   = backemf_const_reg;
    measured_motor_parameters[`IND_MSB:`IND_LSB] = inductance_reg;
  end

  // ***********************************************
  // Parameter measurement status word
  // ***********************************************
  // Layout is owned by the measurement engine; stored as delivered
  logic [31:0] parameter_measurement_status_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      parameter_measurement_status_reg <= `STATUS_RESET;
    end else if (measure_status_load) begin
      parameter_measurement_status_reg <= measure_status_in;
    end
  end

  // ***********************************************
  // Host register port
  // ***********************************************
  // Every access is answered one cycle later. Writes change nothing,
  // and unlisted offsets read zero so a stray host access is harmless.
  logic [31:0] read_word;
  logic        ack_reg;
  logic [31:0] rdata_reg;
  logic        host_read;
  logic        host_write;

  // Write data is not used: every field here is read-only
  assign host_read  = host_req.rd;
  assign host_write = host_req.wr & ~host_req.rd;

  always_comb begin
    unique case (host_req.addr)
      `OFS_CONTROLLER_FAULT_FLAGS: begin
        read_word = controller_fault_flags;
      end
      `OFS_ALGORITHM_STATUS: begin
        read_word = algorithm_status;
      end
      `OFS_MEASURED_MOTOR_PARAMETERS: begin
        read_word = measured_motor_parameters;
      end
      `OFS_PARAMETER_MEASUREMENT_STATUS: begin
        read_word = parameter_measurement_status_reg;
      end
      default: begin
        read_word = `STATUS_RESET;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= host_read | host_write;
    end
  end

  // A read captures the addressed word; a write answers with zero
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_reg <= `STATUS_RESET;
    end else if (host_read) begin
      rdata_reg <= read_word;
    end else if (host_write) begin
      rdata_reg <= `STATUS_RESET;
    end
  end

  assign host_rsp.ack   = ack_reg;
  assign host_rsp.rdata = rdata_reg;

endmodule

`default_nettype wire

// ---- tb/status_regs_chk.sv ----
// Concurrent checks on the status register bank ports
`include "status_map.svh"
`timescale 1ns/1ns
`default_nettype none
module status_regs_chk (
  input wire logic                   clock,
  input wire logic                   rst,
  input wire status_pkg::host_req_t  host_req,
  input wire status_pkg::host_rsp_t  host_rsp,
  input wire status_pkg::fault_src_t fault_src,
  input wire logic                   fault_clear,
  input wire status_pkg::algo_src_t  algo_src,
  input wire logic                   controller_fault
);
  import status_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ***********************************************
  // Read sequences and assertions
  // ***********************************************
  sequence rd_at(logic [7:0] a);
    host_req.rd && host_req.addr == a;
  endsequence
  sequence rd_algo_fresh;
    rd_at(`OFS_ALGORITHM_STATUS) ##0 !$past(rst);
  endsequence
  a_summary_or: assert property (rd_at(`OFS_CONTROLLER_FAULT_FLAGS) |=>
    host_rsp.rdata[31] == (|host_rsp.rdata[30:0])) else $error("fault summary bit not OR of flags");
  a_summary_pin: assert property (rd_at(`OFS_CONTROLLER_FAULT_FLAGS) |=>
    host_rsp.rdata[31] == $past(controller_fault)) else $error("summary pin differs from summary bit");
  a_lock_any: assert property (rd_at(`OFS_CONTROLLER_FAULT_FLAGS) |=>
    host_rsp.rdata[20] == (|(host_rsp.rdata & `FAULT_LOCK_MASK))) else $error("lock summary wrong");
  a_fault_gap: assert property (rd_at(`OFS_CONTROLLER_FAULT_FLAGS) |=>
    host_rsp.rdata[13:4] == 10'h000) else $error("reserved fault bits not zero");
  a_algo_word: assert property (rd_algo_fresh |=>
    host_rsp.rdata == {$past(algo_src, 2), 2'b00}) else $error("algorithm status word wrong");
  a_param_gap: assert property (rd_at(`OFS_MEASURED_MOTOR_PARAMETERS) |=>
    host_rsp.rdata[7:0] == 8'h00) else $error("reserved parameter byte not zero");
  a_write_void: assert property (host_req.wr && !host_req.rd |=>
    host_rsp.ack && host_rsp.rdata == 32'h0) else $error("write answer wrong");
  a_unmapped_zero: assert property (host_req.rd && !(host_req.addr inside {8'hE2, 8'hE4, 8'hE6, 8'hE8})
    |=> host_rsp.rdata == 32'h0) else $error("unmapped read not zero");
  a_fault_set: assert property (fault_src != '0 |=> controller_fault) else $error("fault not flagged");
  a_ack_single: assert property (!host_req.rd && !host_req.wr |=> !host_rsp.ack) else $error("ack without access");
  a_fault_clear: assert property (fault_clear && fault_src == '0 |=>
    !controller_fault) else $error("fault summary not cleared");
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the status register bank
`include "status_map.svh"
`timescale 1ns/1ns
`default_nettype none
`define CHECK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin n_errors++; $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module tb_top;
  import status_pkg::*;
  logic          clock;
  logic          rst;
  logic          fault_clear;
  logic          params_load;
  logic          measure_status_load;
  logic          controller_fault;
  logic [31:0]   measure_status_in;
  host_req_t     host_req;
  host_rsp_t     host_rsp;
  fault_src_t    fault_src;
  algo_src_t     algo_src;
  motor_params_t params_in;
  int            n_errors;
  int            checks_done;
  // Register bit set by each fault source index
  localparam int POS [20] = '{0, 1, 2, 3, 14, 15, 16, 17, 18, 19, 21, 22, 23, 24, 25, 26, 27, 28, 29, 30};
  localparam logic [7:0] OFS [6] = '{8'hE2, 8'hE4, 8'hE6, 8'hE8, 8'hEA, 8'hE0};
  status_regs u_dut (.clock(clock), .rst(rst), .host_req(host_req), .host_rsp(host_rsp),
    .fault_src(fault_src), .fault_clear(fault_clear), .algo_src(algo_src), .params_load(params_load),
    .params_in(params_in), .measure_status_load(measure_status_load),
    .measure_status_in(measure_status_in), .controller_fault(controller_fault));
  // ***********************************************
  // Bus and reset tasks
  // ***********************************************
  task automatic access(input logic w, input logic [7:0] a, input logic [31:0] e, input string nm);
    @(negedge clock);
    host_req.rd = !w;
    host_req.wr = w;
    host_req.addr = a;
    host_req.wdata = 32'hFFFF_FFFF;
    @(negedge clock);
    host_req = '0;
    `CHECK("ack", 1'b1, host_rsp.ack)
    `CHECK(nm, e, host_rsp.rdata)
  endtask
  task automatic do_reset;
    algo_src = '0;
    @(negedge clock);
    rst = 1'b1;
    repeat (6) @(negedge clock);
    rst = 1'b0;
  endtask
  // ***********************************************
  // Scenarios
  // ***********************************************
  task automatic t_reset;
    for (int i = 0; i < 4; i++) access(1'b0, OFS[i], 32'h0, "reset word");
    `CHECK("summary pin", 1'b0, controller_fault)
    $display("test reset done");
  endtask
  task automatic t_faults;
    logic [31:0] e;
    for (int i = 0; i < 20; i++) begin
      e = (32'h1 << POS[i]) | 32'h8000_0000;
      if ((e & `FAULT_LOCK_MASK) != 32'h0) e = e | 32'h0010_0000;
      @(negedge clock);
      fault_src = fault_src_t'(20'h1 << i);
      access(1'b0, 8'hE2, e, "fault word");
      `CHECK("summary pin", 1'b1, controller_fault)
      @(negedge clock);
      fault_src = '0;
      fault_clear = 1'b1;
      @(negedge clock);
      fault_clear = 1'b0;
      access(1'b0, 8'hE2, 32'h0, "cleared word");
      `CHECK("summary pin", 1'b0, controller_fault)
    end
    @(negedge clock);
    fault_src.motor_absent = 1'b1;
    fault_clear = 1'b1;
    @(negedge clock);
    fault_src = '0;
    fault_clear = 1'b0;
    access(1'b0, 8'hE2, 32'h8030_0000, "set beats clear");
    $display("test faults done");
  endtask
  task automatic t_algo;
    @(negedge clock);
    algo_src = '{16'hFFFF, 12'hFFF, 1'b1, 1'b0};
    access(1'b0, 8'hE4, 32'hFFFF_FFF8, "algo word");
    algo_src = '{16'h8000, 12'h001, 1'b0, 1'b1};
    access(1'b0, 8'hE4, 32'h8000_0014, "algo word");
    $display("test algo done");
  endtask
  task automatic t_params;
    @(negedge clock);
    params_in = '{8'hA5, 8'h5A, 8'hC3};
    measure_status_in = 32'hF500_0000;
    params_load = 1'b1;
    measure_status_load = 1'b1;
    @(negedge clock);
    params_load = 1'b0;
    measure_status_load = 1'b0;
    params_in = '0;
    measure_status_in = 32'h0;
    access(1'b0, 8'hE6, 32'hA55A_C300, "param word");
    access(1'b0, 8'hE8, 32'hF500_0000, "measure word");
    $display("test params done");
  endtask
  task automatic t_writes;
    logic [31:0] keep [6];
    keep = '{32'h8030_0000, 32'h8000_0014, 32'hA55A_C300, 32'hF500_0000, 32'h0, 32'h0};
    for (int i = 0; i < 6; i++) begin
      if (i < 4) access(1'b1, OFS[i], 32'h0, "write answer");
      access(1'b0, OFS[i], keep[i], "after write");
    end
    $display("test writes done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    #800000;
    n_errors++;
    finish_test;
  end
  initial begin
    {rst, fault_clear, params_load, measure_status_load} = 4'h0;
    {host_req, fault_src, params_in, measure_status_in} = '0;
    algo_src = '0;
    n_errors = 0;
    checks_done = 0;
    do_reset;
    t_reset;
    t_faults;
    t_algo;
    t_params;
    t_writes;
    do_reset;
    t_reset;
    finish_test;
  end
endmodule
bind status_regs status_regs_chk u_chk (.clock(clock), .rst(rst), .host_req(host_req), .host_rsp(host_rsp),
  .fault_src(fault_src), .fault_clear(fault_clear), .algo_src(algo_src), .controller_fault(controller_fault));
`default_nettype wire
